// ==== shared/psr_pkg.sv ====
// Package with register map, field positions and carrier types of the port status bank.
package psr_pkg;

    // ==========================================================
    // Register addresses on the management interface.
    localparam logic [4:0] PSR_ADDR_CONTROL   = 5'h00;
    localparam logic [4:0] PSR_ADDR_STATUS    = 5'h01;
    localparam logic [4:0] PSR_ADDR_ID_HIGH   = 5'h02;
    localparam logic [4:0] PSR_ADDR_ID_LOW    = 5'h03;

    // ==========================================================
    // Status register field positions.
    localparam int PSR_BIT_FOUR_PAIR   = 15;
    localparam int PSR_BIT_FAST_FULL   = 14;
    localparam int PSR_BIT_FAST_HALF   = 13;
    localparam int PSR_BIT_SLOW_FULL   = 12;
    localparam int PSR_BIT_SLOW_HALF   = 11;
    localparam int PSR_BIT_PREAMBLE_OK = 6;
    localparam int PSR_BIT_AN_DONE     = 5;
    localparam int PSR_BIT_REM_FAULT   = 4;
    localparam int PSR_BIT_AN_CAPABLE  = 3;
    localparam int PSR_BIT_LINK_UP     = 2;
    localparam int PSR_BIT_JABBER      = 1;
    localparam int PSR_BIT_EXT_REGS    = 0;
    // Control register restart bit position.
    localparam int PSR_BIT_AN_RESTART  = 9;

    // ==========================================================
    // Fixed status bits: abilities, preamble suppression, capability, extended set.
    localparam logic [15:0] PSR_STATUS_FIXED  = 16'h7849;
    // Reset value of the latched status bits.
    localparam logic        PSR_LATCH_RESET   = 1'b0;
    localparam logic [15:0] PSR_READ_IDLE     = 16'h0000;

    // ==========================================================
    // Identity values; all four defaults are arbitrary.
    localparam logic [15:0] PSR_OUI_HIGH_DEF  = 16'h1234;
    localparam logic [5:0]  PSR_OUI_LOW_DEF   = 6'h2A;
    localparam logic [5:0]  PSR_MODEL_DEF     = 6'h15;
    localparam logic [3:0]  PSR_REV_DEF       = 4'h3;

    // ==========================================================
    // Management access request from the frame engine.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } psr_req_t;

    // Raw events from the link, fault, jabber and negotiation machinery.
    typedef struct packed {
        logic link_ok;
        logic rem_fault;
        logic jabber;
        logic an_done;
        logic an_start;
    } psr_evt_t;

endpackage : psr_pkg

// ==== verilog/psr_regs.sv ====
// Port status and identifier register bank of one transceiver port.
// Notes on behaviour
// - Bit 15 four-pair ability always reads 0.
// - Bits 14 to 11 abilities always read 1.
// - Bits 10 to 7 reserved, read 0.
// - Bit 6 reads 1; preambleless frames accepted.
// - Bit 5 shows negotiation done; resets 0.
// - Negotiation start clears the done bit.
// - Bit 4 remote fault sticks until read.
// - Bit 3 negotiation capability always reads 1.
// - Bit 2 shows valid link established.
// - Link bit latches low until read.
// - Bit 1 jabber sticks until read and ended.
// - Identifier bits in high and low registers.
// - Low identifier bits 9:4 hold model.
// - Low identifier bits 3:0 hold revision.
// - Writing restart bit clears done immediately.
`timescale 1ns/1ps
`default_nettype none

module psr_regs
    import psr_pkg::*;
#(
    parameter logic [15:0] OUI_HIGH = PSR_OUI_HIGH_DEF, // Arbitrary value.
    parameter logic [5:0]  OUI_LOW  = PSR_OUI_LOW_DEF,  // Arbitrary value.
    parameter logic [5:0]  MODEL    = PSR_MODEL_DEF,    // Arbitrary value.
    parameter logic [3:0]  REVISION = PSR_REV_DEF       // Arbitrary value.
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire psr_req_t    req_i,
    input  wire psr_evt_t    evt_i,
    output logic [15:0]      rdata_o,
    output logic             rvalid_o,
    output logic             an_restart_o
);

    // ==========================================================
    // State. Every flag below but the status_rd and restart_wr strobes is a plain flip-flop on the core clock; the event
    // inputs come from logic on the same clock, so none of them is synchronised.
    logic        an_done_ff;
    logic        rem_fault_ff;
    logic        link_up_ff;
    logic        jabber_ff;
    logic [15:0] rdata_ff;
    logic        rvalid_ff;
    logic        an_restart_ff;
    logic [15:0] nxt_rdata;
    logic        status_rd;
    logic        restart_wr;

    // Decodes an access to one register.
    function automatic logic hit(input psr_req_t r, input logic [4:0] a);
        return r.addr == a;
    endfunction : hit

    // Builds the status word from its fixed fields and the four latched bits.
    // Starting from the idle word keeps every reserved position at zero, and
    // the loop below spells out that range so it cannot be filled by accident.
    function automatic logic [15:0] status_word(
        input logic done,
        input logic fault,
        input logic link,
        input logic jab
    );
        logic [15:0] w;
        w = PSR_READ_IDLE;
        for (int b = PSR_BIT_PREAMBLE_OK + 1; b < PSR_BIT_SLOW_HALF; b++) begin
            w[b] = 1'b0;
        end
        w[PSR_BIT_FOUR_PAIR]   = 1'b0;
        w[PSR_BIT_FAST_FULL]   = 1'b1;
        w[PSR_BIT_FAST_HALF]   = 1'b1;
        w[PSR_BIT_SLOW_FULL]   = 1'b1;
        w[PSR_BIT_SLOW_HALF]   = 1'b1;
        w[PSR_BIT_PREAMBLE_OK] = 1'b1;
        w[PSR_BIT_AN_DONE]     = done;
        w[PSR_BIT_REM_FAULT]   = fault;
        w[PSR_BIT_AN_CAPABLE]  = 1'b1;
        w[PSR_BIT_LINK_UP]     = link;
        w[PSR_BIT_JABBER]      = jab;
        w[PSR_BIT_EXT_REGS]    = 1'b1;
        return w;
    endfunction : status_word

    // Packs the low identifier word: vendor tail, model, then revision.
    // Each field keeps its own width, so no field can spill into its neighbour.
    function automatic logic [15:0] id_low_word(
        input logic [5:0] vendor_tail,
        input logic [5:0] model,
        input logic [3:0] revision
    );
        return {vendor_tail, model, revision};
    endfunction : id_low_word

    // Status read and restart write strobes from the management engine.
    // Only bit 9 of a control write acts here; the other control bits belong to
    // logic outside this bank, and writes to any other address are dropped.
    assign status_rd  = req_i.rd && hit(req_i, PSR_ADDR_STATUS);
    assign restart_wr = req_i.wr && hit(req_i, PSR_ADDR_CONTROL)
                        && req_i.wdata[PSR_BIT_AN_RESTART];

    // ==========================================================
    // Negotiation complete flag; a start or restart clears it, done wins if coincident.
    // Letting completion win means a finish landing in the cycle of a restart is
    // not lost; the restart pulse still goes out and negotiation runs again.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            an_done_ff <= PSR_LATCH_RESET;
        end else if (evt_i.an_done) begin
            an_done_ff <= 1'b1;
        end else if (evt_i.an_start || restart_wr) begin
            an_done_ff <= 1'b0;
        end
    end

    // Restart request toward the negotiation machinery, one cycle pulse.
    // The pulse is registered so that the output leaves a flip-flop.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            an_restart_ff <= 1'b0;
        end else begin
            an_restart_ff <= restart_wr;
        end
    end

    // ==========================================================
    // Remote fault sticks high; a read clears it unless a new fault arrives.
    // The read that clears the bit has already captured it as one, so a fault
    // is always seen by software at least once before it goes away.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rem_fault_ff <= PSR_LATCH_RESET;
        end else if (evt_i.rem_fault) begin
            rem_fault_ff <= 1'b1;
        end else if (status_rd) begin
            rem_fault_ff <= 1'b0;
        end
    end

    // Link bit latches low; a read reloads it from the live link state.
    // A failure shorter than a read interval still leaves the bit at zero, so
    // software always learns that the link dropped, even if it came back.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_up_ff <= PSR_LATCH_RESET;
        end else if (!evt_i.link_ok) begin
            link_up_ff <= 1'b0;
        end else if (status_rd) begin
            link_up_ff <= 1'b1;
        end
    end

    // Jabber sticks until both a read has happened and the condition has ended.
    // A read taken while jabber is still present leaves the bit set; the next
    // read after the condition ends is the one that clears it.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            jabber_ff <= PSR_LATCH_RESET;
        end else if (evt_i.jabber) begin
            jabber_ff <= 1'b1;
        end else if (status_rd) begin
            jabber_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Read multiplexer; status returns latched values before their clear lands.
    always_comb begin
        nxt_rdata = PSR_READ_IDLE;
        unique case (req_i.addr)
            PSR_ADDR_STATUS: begin
                nxt_rdata = status_word(an_done_ff,
                                        rem_fault_ff,
                                        link_up_ff,
                                        jabber_ff);
            end
            PSR_ADDR_ID_HIGH: begin
                nxt_rdata = OUI_HIGH;
            end
            PSR_ADDR_ID_LOW: begin
                nxt_rdata = id_low_word(OUI_LOW, MODEL, REVISION);
            end
            default: begin
                nxt_rdata = PSR_READ_IDLE;
            end
        endcase
    end

    // Read data register, loaded one cycle after the read strobe.
    // The word holds between reads, so a slow frame engine can shift it out.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff  <= PSR_READ_IDLE;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= req_i.rd;
            if (req_i.rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // Outputs come straight from their flip-flops.
    assign rdata_o      = rdata_ff;
    assign rvalid_o     = rvalid_ff;
    assign an_restart_o = an_restart_ff;

endmodule : psr_regs

`default_nettype wire

// ==== testbench/psr_mgmt_model.sv ====
// Management controller model issuing register accesses.
`timescale 1ns/1ps
`default_nettype none
module psr_mgmt_model
    import psr_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rvalid_i,
    output var psr_req_t req_o
);
    int misses = 0;
    // ==========================================================
    // One-cycle strobe; answer expected exactly one cycle later.
    // Any address is passed through unchanged; no register range is kept out of reach.
    task automatic access(input logic rd, input logic [4:0] addr, input logic [15:0] wdata);
        @(posedge core_clk_i);
        req_o <= '{rd: rd, wr: !rd, addr: addr, wdata: wdata};
        @(posedge core_clk_i);
        req_o <= '0;
        #1;
        if (rd && rvalid_i !== 1'b1) begin
            misses++;
            $display("mismatch at %0t: no read answer", $time);
        end
    endtask : access
    initial req_o = '0;
endmodule : psr_mgmt_model
`default_nettype wire

// ==== testbench/psr_regs_chk.sv ====
// Checker of the port status bank ports.
`timescale 1ns/1ps
`default_nettype none
module psr_regs_chk
    import psr_pkg::*;
#(
    parameter logic [15:0] OUI_HIGH = 16'h0000, parameter logic [5:0] OUI_LOW = 6'h00,
    parameter logic [5:0]  MODEL    = 6'h00,    parameter logic [3:0] REVISION = 4'h0
) (
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire psr_req_t    req_i,
    input wire psr_evt_t    evt_i,
    input wire logic [15:0] rdata_o,
    input wire logic        rvalid_o,
    input wire logic        an_restart_o
);
    // ==========================================================
    // Read answers tied to the events that came before them.
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence st_rd;
        req_i.rd && req_i.addr == PSR_ADDR_STATUS;
    endsequence
    sequence hi_rd;
        req_i.rd && req_i.addr == PSR_ADDR_ID_HIGH;
    endsequence
    sequence lo_rd;
        req_i.rd && req_i.addr == PSR_ADDR_ID_LOW;
    endsequence
    sequence rs_wr;
        req_i.wr && req_i.addr == PSR_ADDR_CONTROL && req_i.wdata[PSR_BIT_AN_RESTART];
    endsequence
    rd_answer_a: assert property (req_i.rd |=> rvalid_o) else $error("no answer");
    fixed_bits_a: assert property (st_rd |=> (rdata_o & 16'hFFC9) == 16'h7849)
        else $error("fixed bits");
    id_high_a: assert property (hi_rd |=> rdata_o == OUI_HIGH) else $error("id high");
    id_low_a: assert property (lo_rd |=> rdata_o == {OUI_LOW, MODEL, REVISION})
        else $error("id low");
    restart_pulse_a: assert property (rs_wr |=> an_restart_o) else $error("restart");
    link_low_a: assert property ((!evt_i.link_ok ##1 st_rd) |=> !rdata_o[2])
        else $error("link");
    fault_stick_a: assert property ((evt_i.rem_fault ##1 st_rd) |=> rdata_o[4])
        else $error("fault");
    jabber_stick_a: assert property ((evt_i.jabber ##1 st_rd) |=> rdata_o[1])
        else $error("jabber");
    done_clear_a: assert property (
        (evt_i.an_start && !evt_i.an_done ##1 st_rd) |=> !rdata_o[5]) else $error("done");
    restart_clear_a: assert property (
        (rs_wr ##0 !evt_i.an_done ##1 !evt_i.an_done ##1 st_rd) |=> !rdata_o[5])
        else $error("restart done");
    link_reload_a: assert property (
        (st_rd ##0 evt_i.link_ok ##1 evt_i.link_ok ##1 st_rd) |=> rdata_o[2])
        else $error("link up");
endmodule : psr_regs_chk
bind psr_regs psr_regs_chk #(.OUI_HIGH(OUI_HIGH), .OUI_LOW(OUI_LOW), .MODEL(MODEL),
    .REVISION(REVISION)) u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
    .evt_i(evt_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .an_restart_o(an_restart_o));
`default_nettype wire

// ==== testbench/psr_regs_test.sv ====
// Self-checking bench of the port status bank.
`timescale 1ns/1ps
`default_nettype none
module psr_regs_test
    import psr_pkg::*;
;
    logic        core_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    psr_evt_t    evt = '0;
    psr_req_t    req;
    logic [15:0] rdata, exp_q;
    logic        rvalid, restart, exp_v, exp_rs, lk, fl, jb, dn;
    int          seed = 91;
    int          err_total = 0;
    int          checks = 0;
    wire         st = req.rd && req.addr == 5'h01;
    wire         rs = req.wr && req.addr == 5'h00 && req.wdata[9];
    always #2 core_clk_i = ~core_clk_i;
    psr_regs uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req), .evt_i(evt),
        .rdata_o(rdata), .rvalid_o(rvalid), .an_restart_o(restart));
    psr_mgmt_model mgmt (.core_clk_i(core_clk_i), .rvalid_i(rvalid), .req_o(req));
    // ==========================================================
    // Expected read word from the modelled latches.
    function automatic logic [15:0] expect_read(input logic [4:0] a);
        case (a)
            5'h01: return 16'h7849 | {10'h000, dn, fl, 1'b0, lk, jb, 1'b0};
            5'h02: return PSR_OUI_HIGH_DEF;
            5'h03: return {PSR_OUI_LOW_DEF, PSR_MODEL_DEF, PSR_REV_DEF};
            default: return 16'h0000;
        endcase
    endfunction : expect_read
    // Reference latches, updated after the read has captured them.
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {exp_v, exp_rs, lk, fl, jb, dn} <= '0;
        end else begin
            exp_v <= req.rd;
            exp_rs <= rs;
            if (req.rd) exp_q <= expect_read(req.addr);
            lk <= evt.link_ok && (lk || st);
            fl <= evt.rem_fault || (fl && !st);
            jb <= evt.jabber || (jb && !st);
            dn <= evt.an_done || (dn && !evt.an_start && !rs);
        end
    end
    // Random events at a low rate, link mostly up.
    always @(posedge core_clk_i) begin
        evt <= '{link_ok: $random(seed) % 8 != 0, rem_fault: $random(seed) % 9 == 0,
            jabber: $random(seed) % 7 == 0, an_done: $random(seed) % 11 == 0,
            an_start: $random(seed) % 13 == 0};
    end
    task automatic mism(input string msg);
        err_total++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask : mism
    // Outputs compared where they are settled.
    always @(negedge core_clk_i) begin
        if (rst_n_i) begin
            checks++;
            if (rvalid !== exp_v || restart !== exp_rs) mism("strobe");
            if (exp_v && rdata !== exp_q) mism("read data");
        end else if (rdata !== 16'h0000 || rvalid !== 1'b0 || restart !== 1'b0) begin
            mism("reset value");
        end
    end
    task automatic complete_run();
        err_total += mgmt.misses;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // Reset, corner cases, then random accesses.
    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        mgmt.access(1'b1, 5'h01, 16'h0000);
        mgmt.access(1'b1, 5'h02, 16'h0000);
        mgmt.access(1'b1, 5'h03, 16'h0000);
        mgmt.access(1'b1, 5'h1F, 16'h0000);
        mgmt.access(1'b0, 5'h01, 16'hFFFF);
        mgmt.access(1'b0, 5'h00, 16'h0200);
        for (int i = 0; i < 3000; i++) begin
            if (i == 1500) begin
                rst_n_i <= 1'b0;
                repeat (3) @(posedge core_clk_i);
                rst_n_i <= 1'b1;
            end
            mgmt.access($random(seed) % 3 != 0, 5'($random(seed) & 3), 16'($random(seed)));
        end
        complete_run();
    end
endmodule : psr_regs_test
`default_nettype wire
